// ---- rtl/nco_preset_regs_channel_a.sv ----
// Channel A numeric_oscillator preset register bank with preset selection
`timescale 1ns/1ps
`default_nettype none
`include "nco_preset_defs.svh"


module nco_preset_regs_channel_a
    import nco_preset_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] preset_sel_i,
    input wire logic [31:0] freq_preset0_i,
    output nco_setting_type nco_setting_o,
    output logic freq_changed_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Frequency preset 0 lives outside this bank; index 0 of freq is unused storage-free.
    logic [31:0] freq [1:3];
    logic [15:0] phase [0:3];
    reg_req_type req;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Decode: returns index and whether the address is a frequency or phase preset
    function automatic logic [3:0] decode(input logic [11:0] a);
        // bit3 hit, bit2 is_phase, bits1:0 index
        case (a)
            `OFF_NCO_PHASE_A_PRESET0: decode = 4'hc;
            `OFF_NCO_FREQ_A_PRESET1: decode = 4'h9;
            `OFF_NCO_PHASE_A_PRESET1: decode = 4'hd;
            `OFF_NCO_FREQ_A_PRESET2: decode = 4'ha;
            `OFF_NCO_PHASE_A_PRESET2: decode = 4'he;
            `OFF_NCO_FREQ_A_PRESET3: decode = 4'hb;
            `OFF_NCO_PHASE_A_PRESET3: decode = 4'hf;
            default: decode = 4'h0;
        endcase
    endfunction : decode

    logic [3:0] wdec;
    logic [3:0] rdec;

    assign wdec = decode(req.addr);
    assign rdec = wdec;

    // ------------------------------------------------------------
    // Frequency presets
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 1; i < `PRESET_COUNT; i++) begin
                freq[i] <= `RST_NCO_FREQ;
            end
        end else if (req.wr && wdec[3] && !wdec[2]) begin
            freq[wdec[1:0]] <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Phase presets
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `PRESET_COUNT; i++) begin
                phase[i] <= `RST_NCO_PHASE;
            end
        end else if (req.wr && wdec[3] && wdec[2]) begin
            phase[wdec[1:0]] <= req.wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Read port, one cycle latency; unmapped reads give zero
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h00000000;
        end else if (req.rd && rdec[3]) begin
            if (rdec[2]) begin
                rdata_o <= {16'h0000, phase[rdec[1:0]]};
            end else begin
                rdata_o <= freq[rdec[1:0]];
            end
        end else begin
            rdata_o <= 32'h00000000;
        end
    end

    // Pulse telling the sync logic a frequency changed, so software knows to re-sync
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            freq_changed_o <= 1'b0;
        end else begin
            freq_changed_o <= req.wr && wdec[3] && !wdec[2];
        end
    end

    // ------------------------------------------------------------
    // Oscillator feed
    // ------------------------------------------------------------
    // Registered pair: both words switch on the same edge, so the accumulator
    // never sees a frequency from one preset with a phase from another.
    // Left-justified phase scales to preset * 2^-16 turns and wraps modulo 2^32,
    // so signed and unsigned views give the same angle.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            nco_setting_o <= '{freq_word: 32'h00000000, phase_word: 32'h00000000};
        end else begin
            nco_setting_o.freq_word <= (preset_sel_i == 2'h0) ? freq_preset0_i
                                       : freq[preset_sel_i];
            nco_setting_o.phase_word <= {phase[preset_sel_i],
                                         16'h0000};
        end
    end

endmodule : nco_preset_regs_channel_a
`default_nettype wire

// ---- rtl/nco_preset_defs.svh ----
// Register offsets, reset values and field layout of the channel A oscillator presets
`ifndef NCO_PRESET_DEFS_SVH
`define NCO_PRESET_DEFS_SVH

`define ADDR_WIDTH 12
`define DATA_WIDTH 32
`define FREQ_WIDTH 32
`define PHASE_WIDTH 16
`define PRESET_COUNT 4
`define SEL_WIDTH 2

`define OFF_NCO_PHASE_A_PRESET0 12'h224
`define OFF_NCO_FREQ_A_PRESET1 12'h228
`define OFF_NCO_PHASE_A_PRESET1 12'h22c
`define OFF_NCO_FREQ_A_PRESET2 12'h230
`define OFF_NCO_PHASE_A_PRESET2 12'h234
`define OFF_NCO_FREQ_A_PRESET3 12'h238
`define OFF_NCO_PHASE_A_PRESET3 12'h23c

`define RST_NCO_FREQ 32'hc0000000
`define RST_NCO_PHASE 16'h0000
`define PHASE_PAD_BITS 16

`endif

// ---- rtl/nco_preset_pkg.sv ----
// Types shared by the channel A oscillator preset bank
package nco_preset_pkg;

    // Word pair handed to the oscillator accumulator
    typedef struct packed {
        logic [31:0] freq_word;
        logic [31:0] phase_word;
    } nco_setting_type;

    // Register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage : nco_preset_pkg

// ---- tb/nco_preset_checks_assertions.sv ----
// Port-level assertions for the channel A oscillator preset bank
`timescale 1ns/1ps
`default_nettype none
module nco_preset_checks
    import nco_preset_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] preset_sel_i,
    input wire logic [31:0] freq_preset0_i,
    input wire nco_setting_type nco_setting_o,
    input wire logic freq_changed_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    phase_low_a: assert property (nco_setting_o.phase_word[15:0] == 16'h0000)
        else $error("phase low half set");
    sel0_freq_a: assert property (preset_sel_i == 2'h0 |=>
        nco_setting_o.freq_word == $past(freq_preset0_i)) else $error("preset 0 freq");
    // Reset guard: the first edge after release legitimately loads a new setting
    sel_hold_a: assert property (preset_sel_i != 2'h0 && $stable(preset_sel_i) &&
        !$past(wr_i) && $past(rst_n_i) |=> $stable(nco_setting_o)) else $error("setting moved");
    rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0) else $error("stray rdata");
    phase_hi_a: assert property (rd_i && addr_i[2] |=> rdata_o[31:16] == 16'h0000)
        else $error("phase upper bits");
    unmapped_a: assert property (rd_i && addr_i[11:8] != 4'h2 |=> rdata_o == 32'h0)
        else $error("unmapped read");
    wr_rd_a: assert property (wr_i && addr_i == 12'h228 ##1 rd_i && addr_i == 12'h228
        |=> rdata_o == $past(wdata_i, 2)) else $error("readback");
    freq_pulse_a: assert property (##1 freq_changed_o ==
        $past(wr_i && addr_i inside {12'h228, 12'h230, 12'h238})) else $error("freq pulse");
endmodule : nco_preset_checks
bind nco_preset_regs_channel_a nco_preset_checks u_checks (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .preset_sel_i(preset_sel_i), .freq_preset0_i(freq_preset0_i),
    .nco_setting_o(nco_setting_o), .freq_changed_o(freq_changed_o));
`default_nettype wire

// ---- tb/nco_preset_regs_channel_a_bench.sv ----
// Self-checking bench for the channel A oscillator preset bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
module nco_preset_regs_channel_a_bench
    import nco_preset_pkg::*;
();
    logic clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, pend = 0, freq_changed_o;
    logic [11:0] addr_i = 0, pa;
    logic [31:0] wdata_i = 0, rdata_o, freq_preset0_i = 0, exp_d = 0, exp_q = 0, f, p;
    logic [1:0] preset_sel_i = 0;
    nco_setting_type nco_setting_o;
    int failures = 0, n_checks = 0, cyc = 0;
    nco_preset_regs_channel_a DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .preset_sel_i(preset_sel_i), .freq_preset0_i(freq_preset0_i),
        .nco_setting_o(nco_setting_o), .freq_changed_o(freq_changed_o));
    initial forever #5 clock_i = ~clock_i;
    function automatic nco_setting_type want(input logic [31:0] fw, input logic [15:0] pw);
        return {fw, pw, 16'h0000};
    endfunction : want
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, e);
        @(posedge clock_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        exp_d <= e;
    endtask : acc
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Read data only stand one cycle, so they are judged at the edge right after
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        pend <= rd_i;
        exp_q <= exp_d;
        if (pend) `CHK(rdata_o, exp_q)
        if (cyc == 3000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h44f3d0f0));
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pa = 12'h224 + 12'(8 * i);
            acc(1'b0, pa, 32'h0, 32'h0);
            if (i > 0) acc(1'b0, pa - 12'h004, 32'h0, 32'hc0000000);
        end
        acc(1'b1, 12'h300, $urandom, 32'h0);
        acc(1'b0, 12'h300, 32'h0, 32'h0);
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 4; i++) begin
                pa = 12'h224 + 12'(8 * i);
                f = (r == 0) ? 32'hffffffff : $urandom;
                p = (r == 0) ? 32'hffff8000 : $urandom;
                acc(1'b1, pa, p, 32'h0);
                acc(1'b0, pa, 32'h0, {16'h0000, p[15:0]});
                if (i > 0) acc(1'b1, pa - 12'h004, f, 32'h0);
                if (i > 0) acc(1'b0, pa - 12'h004, 32'h0, f);
                freq_preset0_i <= (i == 0) ? f : $urandom;
                preset_sel_i <= 2'(i);
                acc(1'b0, 12'h000, 32'h0, 32'h0);
                repeat (2) @(posedge clock_i);
                #1 `CHK(nco_setting_o, want(f, p[15:0]))
            end
        end
        print_verdict();
    end
endmodule : nco_preset_regs_channel_a_bench
`default_nettype wire
